// ---- logic/axil_regs.sv ----
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the master holds valid and payload until taken.
`timescale 1ns/100ps

module axil_regs
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [`ADDR_BITS-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address
    input wire logic [`ADDR_BITS-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // Read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register file side
    output uart_sum_pkg::reg_wr_s wr,
    output logic wr_fire,
    input wire logic wr_ok,
    output logic [11:0] rd_idx,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [11:0] aw_idx_q, aw_idx_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic arready_q, arready_d;
    logic fire;

    assign fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr.idx = aw_idx_q;
    assign wr.data = w_data_q;
    assign wr.strb = w_strb_q;
    assign wr_fire = fire;
    assign rd_idx = araddr[`ADDR_BITS-1:2];

    // ==========================================================
    // Channel state
    always_comb
    begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_idx_d = aw_idx_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            aw_idx_d = awaddr[`ADDR_BITS-1:2];
        end
        if (wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (fire)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (bvalid_q && bready)
            bvalid_d = 1'b0;
        if (arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rdata_d = rd_data;
            rresp_d = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid_q && rready)
            rvalid_d = 1'b0;
        // Ready one cycle after an idle slot, so each takes at most one item
        awready_d = !aw_have_d && !(awvalid && awready_q);
        wready_d = !w_have_d && !(wvalid && wready_q);
        arready_d = !rvalid_d && !(arvalid && arready_q);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= `RESP_OKAY;
            rdata_q <= 32'h00000000;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_idx_q <= aw_idx_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign arready = arready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

endmodule

// ---- logic/sum_accum.sv ----
// One 8-bit running checksum accumulator.
// Assumes byte events last one cycle and software loads arrive as one-cycle pulses.
`timescale 1ns/100ps

module sum_accum
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Mode
    input wire logic lin_mode,
    input wire logic sum_enable,
    // Byte event
    input wire uart_sum_pkg::byte_evt_s evt,
    // Software load
    input wire logic load,
    input wire logic [7:0] load_value,
    // Result
    output logic [7:0] sum_q
);

    logic [7:0] sum_d;
    logic count_it;

    // ==========================================================
    // Which bytes count
    always_comb
    begin
        count_it = 1'b0;
        if (evt.valid)
        begin
            if (lin_mode)
                count_it = sum_enable || !evt.is_pid;
            else
                count_it = sum_enable;
        end
    end

    // ==========================================================
    // Accumulation; a byte in the load cycle lands on top of the new value
    always_comb
    begin
        sum_d = sum_q;
        if (load)
            sum_d = load_value;
        if (count_it)
            sum_d = sum_d + evt.data;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sum_q <= `SUM_RESET;
        else
            sum_q <= sum_d;
    end

endmodule

// ---- logic/uart_byte_checksum.sv ----
// Transmit and receive checksum accumulators of one UART channel, with registers.
// Assumes one-cycle byte strobes from the serializer and deserializer on aclk.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps

module uart_byte_checksum
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [`ADDR_BITS-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [`ADDR_BITS-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Byte strobes from the serial engines
    input wire logic tx_byte_sent,
    input wire logic tx_byte_is_pid,
    input wire logic [7:0] tx_byte,
    input wire logic rx_byte_recv,
    input wire logic rx_byte_is_pid,
    input wire logic [7:0] rx_byte,
    // Configuration towards the serial engines
    output logic [3:0] mode_q,
    output logic sum_enable_q,
    output logic [5:0] lin_pid_q
);

    uart_sum_pkg::reg_wr_s wr;
    uart_sum_pkg::byte_evt_s tx_evt;
    uart_sum_pkg::byte_evt_s rx_evt;
    logic wr_fire;
    logic wr_ok;
    logic [11:0] rd_idx;
    logic [31:0] rd_data;
    logic rd_ok;
    logic [7:0] send_sum_value;
    logic [7:0] recv_sum_value;
    logic [8:0] first_parameter_q, first_parameter_d;
    logic [7:0] ctl_two_q, ctl_two_d;
    logic [3:0] mode_d;
    logic lin_mode;
    logic load_send;
    logic load_recv;

    // ==========================================================
    // Decoding shared by read and write paths
    function automatic logic idx_mapped(input logic [11:0] idx);
        idx_mapped = (idx == `RECV_SUM_IDX) || (idx == `SEND_SUM_IDX) ||
            (idx == `FIRST_PARAM_IDX) || (idx == `LINE_CTL_TWO_IDX) ||
            (idx == `MODE_CTL_IDX);
    endfunction

    function automatic logic is_lin(input logic [3:0] m);
        is_lin = (m == `MODE_LIN_MASTER) || (m == `MODE_LIN_SLAVE);
    endfunction

    // ==========================================================
    // Bus slave
    axil_regs u_bus
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr(wr),
        .wr_fire(wr_fire),
        .wr_ok(wr_ok),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    assign wr_ok = idx_mapped(wr.idx);
    assign rd_ok = idx_mapped(rd_idx);

    // Narrow registers live in byte lane 0; upper lanes are ignored, except lane 1 for bit 8 of the first parameter
    assign load_send = wr_fire && wr.strb[0] && (wr.idx == `SEND_SUM_IDX);
    assign load_recv = wr_fire && wr.strb[0] && (wr.idx == `RECV_SUM_IDX);

    // ==========================================================
    // Read mux
    always_comb
    begin
        rd_data = 32'h00000000;
        case (rd_idx)
            `RECV_SUM_IDX: rd_data = {24'h000000, recv_sum_value};
            `SEND_SUM_IDX: rd_data = {24'h000000, send_sum_value};
            `FIRST_PARAM_IDX: rd_data = {23'h000000, first_parameter_q};
            `LINE_CTL_TWO_IDX: rd_data = {24'h000000, ctl_two_q};
            `MODE_CTL_IDX: rd_data = {28'h0000000, mode_q};
            default: rd_data = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Control registers
    always_comb
    begin
        first_parameter_d = first_parameter_q;
        ctl_two_d = ctl_two_q;
        mode_d = mode_q;
        if (wr_fire)
        begin
            if (wr.idx == `FIRST_PARAM_IDX)
            begin
                if (wr.strb[0])
                    first_parameter_d[7:0] = wr.data[7:0];
                if (wr.strb[1])
                    first_parameter_d[8] = wr.data[8];
            end
            if ((wr.idx == `LINE_CTL_TWO_IDX) && wr.strb[0])
                ctl_two_d = wr.data[7:0];
            if ((wr.idx == `MODE_CTL_IDX) && wr.strb[0])
                mode_d = wr.data[3:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            first_parameter_q <= `PARAM_RESET;
            ctl_two_q <= `CTL_TWO_RESET;
            mode_q <= `MODE_RESET;
            sum_enable_q <= 1'b0;
            lin_pid_q <= 6'h00;
        end
        else
        begin
            first_parameter_q <= first_parameter_d;
            ctl_two_q <= ctl_two_d;
            mode_q <= mode_d;
            sum_enable_q <= ctl_two_d[`SUM_ENABLE_BIT];
            lin_pid_q <= first_parameter_d[`PID_BITS-1:0];
        end
    end

    assign lin_mode = is_lin(mode_q);

    // ==========================================================
    // Accumulators
    assign tx_evt.valid = tx_byte_sent;
    assign tx_evt.is_pid = tx_byte_is_pid;
    assign tx_evt.data = tx_byte;
    assign rx_evt.valid = rx_byte_recv;
    assign rx_evt.is_pid = rx_byte_is_pid;
    assign rx_evt.data = rx_byte;

    // Selection of counted bytes and the wrap lives in the accumulator
    sum_accum u_send_sum
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .lin_mode(lin_mode),
        .sum_enable(ctl_two_q[`SUM_ENABLE_BIT]),
        .evt(tx_evt),
        .load(load_send),
        .load_value(wr.data[7:0]),
        .sum_q(send_sum_value)
    );

    sum_accum u_recv_sum
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .lin_mode(lin_mode),
        .sum_enable(ctl_two_q[`SUM_ENABLE_BIT]),
        .evt(rx_evt),
        .load(load_recv),
        .load_value(wr.data[7:0]),
        .sum_q(recv_sum_value)
    );

endmodule

// ---- logic/uart_sum_consts.svh ----
// Offsets, field positions, reset values and mode codes of the checksum block.
// Assumes inclusion by bare name from the package, checker and bench files.
`ifndef UART_SUM_CONSTS_SVH
`define UART_SUM_CONSTS_SVH

// ==========================================================
// Register indices (printed offsets, word index)
`define RECV_SUM_IDX 12'h2A2
`define SEND_SUM_IDX 12'h2A4
`define FIRST_PARAM_IDX 12'h2A5
`define LINE_CTL_TWO_IDX 12'h2AD
`define MODE_CTL_IDX 12'h2AB

// ==========================================================
// Byte address of an index is index times four
`define ADDR_BITS 14
`define SUM_RESET 8'h00
`define PARAM_RESET 9'h000
`define CTL_TWO_RESET 8'h00
`define MODE_RESET 4'h0
`define SUM_ENABLE_BIT 3
`define MODE_LSB 0
`define MODE_LIN_MASTER 4'hC
`define MODE_LIN_SLAVE 4'hB
`define PID_BITS 6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- logic/uart_sum_pkg.sv ----
// Types shared by the checksum block and its bus slave.
// Assumes the constants header sits beside it.
`include "uart_sum_consts.svh"

package uart_sum_pkg;

    // Write request as taken by the bus slave
    typedef struct packed {
        logic [11:0] idx;
        logic [31:0] data;
        logic [3:0] strb;
    } reg_wr_s;

    // Byte event from the serializer or deserializer
    typedef struct packed {
        logic valid;
        logic is_pid;
        logic [7:0] data;
    } byte_evt_s;

    typedef enum logic [1:0] {
        AXI_IDLE,
        AXI_RESP
    } axi_state_e;

endpackage

// ---- verif/serial_node_model.sv ----
// Far-side serial node: hands sent and received bytes to the block as strobes.
// Assumes a caller that steps it from the bench clock.
`timescale 1ns/100ps

module serial_node_model
(
    // Clock
    input wire logic aclk,
    // Byte strobes
    output logic tx_byte_sent = 1'h0,
    output logic tx_byte_is_pid = 1'h0,
    output logic [7:0] tx_byte = 8'h00,
    output logic rx_byte_recv = 1'h0,
    output logic rx_byte_is_pid = 1'h0,
    output logic [7:0] rx_byte = 8'h00
);
    // One byte each way in the next cycle; calls may follow back to back
    task automatic put(input logic p, input logic [7:0] t, input logic [7:0] r);
        @(posedge aclk);
        tx_byte_sent <= 1'h1;
        rx_byte_recv <= 1'h1;
        tx_byte_is_pid <= p;
        rx_byte_is_pid <= p;
        tx_byte <= t;
        rx_byte <= r;
    endtask

    // Between frames the data lines carry no meaning, so scramble them
    task automatic idle();
        @(posedge aclk);
        tx_byte_sent <= 1'h0;
        rx_byte_recv <= 1'h0;
        tx_byte_is_pid <= 1'h0;
        rx_byte_is_pid <= 1'h0;
        tx_byte <= ~tx_byte;
        rx_byte <= ~rx_byte;
    endtask
endmodule

// ---- verif/sum_checker.sv ----
// Concurrent checks on the checksum block, watching its top-level ports only.
// Assumes it is bound to the top module, whose port names it reuses.
`timescale 1ns/100ps
`include "uart_sum_consts.svh"

module sum_checker
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [`ADDR_BITS-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Configuration
    input wire logic [3:0] mode_q,
    input wire logic sum_enable_q,
    input wire logic [5:0] lin_pid_q
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic wh;
    logic [31:0] wd_q;
    logic [11:0] wi;

    assign wh = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    assign wi = s_axi_awaddr[13:2];

    // The word lands a cycle or two after it is taken, so keep a copy
    always_ff @(posedge aclk)
    begin
        if (wh)
        begin
            wd_q <= s_axi_wdata;
        end
    end

    reset_idle_a:
        assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && mode_q == 4'h0
            && !sum_enable_q ##1 s_axi_awready && s_axi_wready && s_axi_arready)
        else $error("outputs not idle after reset");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    write_answer_a:
        assert property (wh |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    read_upper_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
        else $error("upper read bits not zero");
    pid_follow_a:
        assert property (wh && wi == `FIRST_PARAM_IDX |=> ##[0:2] lin_pid_q == wd_q[5:0])
        else $error("identifier output not loaded");
    enable_follow_a:
        assert property (wh && wi == `LINE_CTL_TWO_IDX |=> ##[0:2] sum_enable_q == wd_q[3])
        else $error("enable output not loaded");
    mode_follow_a:
        assert property (wh && wi == `MODE_CTL_IDX |=> ##[0:2] mode_q == wd_q[3:0])
        else $error("mode output not loaded");
endmodule

bind uart_byte_checksum sum_checker chk_u (.*);

// ---- verif/tb_top.sv ----
// Self-checking bench: bus tasks, byte bursts in modes 0, LIN slave and LIN master, verdict.
// Assumes the design package and header are compiled first.
`timescale 1ns/100ps
`include "uart_sum_consts.svh"

module tb_top;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, mode_q;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic tx_byte_sent, tx_byte_is_pid, rx_byte_recv, rx_byte_is_pid, sum_enable_q;
    logic [7:0] tx_byte, rx_byte, ts, rs, b;
    logic [5:0] lin_pid_q;
    logic [3:0] modes [3] = '{4'h0, `MODE_LIN_SLAVE, `MODE_LIN_MASTER};
    int mismatches = 0, total_checks = 0;
    localparam logic [13:0] RECV_A = {`RECV_SUM_IDX, 2'h0};
    localparam logic [13:0] SEND_A = {`SEND_SUM_IDX, 2'h0};
    localparam logic [13:0] PARAM_A = {`FIRST_PARAM_IDX, 2'h0};
    localparam logic [13:0] CTL_A = {`LINE_CTL_TWO_IDX, 2'h0};
    localparam logic [13:0] MODE_A = {`MODE_CTL_IDX, 2'h0};

    uart_byte_checksum dut_u (.*);
    serial_node_model node_u (.*);

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Response ready is offered with the request and held until the answer is seen
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (n < 64)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'h0;
                check({30'h0, s_axi_bresp}, {30'h0, er});
                n = 1000;
            end
        end
        if (n < 1000)
        begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (n < 64)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'h0;
                check(s_axi_rdata, e);
                check({30'h0, s_axi_rresp}, {30'h0, er});
                n = 1000;
            end
        end
        if (n < 1000)
        begin
            mismatches++;
            conclude();
        end
    endtask

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(RECV_A, 32'h0);
        rd(SEND_A, 32'h0);
        wr(PARAM_A, 32'h1F5);
        rd(PARAM_A, 32'h1F5);
        check({26'h0, lin_pid_q}, 32'h35);
        wr(14'h0004, 32'h1, 2'h2);
        rd(14'h0004, 32'h0, 2'h2);
        foreach (modes[i])
        begin
            for (int e = 0; e < 2; e++)
            begin
                wr(MODE_A, {28'h0, modes[i]});
                wr(CTL_A, e ? 32'h8 : 32'h0);
                wr(SEND_A, 32'hABCDEF90);
                wr(RECV_A, 32'h5A);
                ts = 8'h90;
                rs = 8'h5A;
                // First byte is the identifier from the first parameter
                for (int k = 0; k < 4; k++)
                begin
                    b = 8'h35 + 8'h5B * k[7:0];
                    node_u.put(k == 0, b, ~b);
                    if (e == 1 || (i > 0 && k > 0))
                    begin
                        ts += b;
                        rs += ~b;
                    end
                end
                node_u.idle();
                rd(SEND_A, {24'h0, ts});
                rd(RECV_A, {24'h0, rs});
                check({28'h0, mode_q}, {28'h0, modes[i]});
                check({31'h0, sum_enable_q}, e);
            end
        end
        conclude();
    end
endmodule
